/* File: core/psp_program_port.sv */
`timescale 1ns/1ps
// Summary of operation
// - Ten-bit bus plus three load strobes
// - Start strobes take all ten bits
// - Mode strobe edge: bits 9:8 select, 7:0 written
// - Clear low zeroes mode registers only
// - Start values follow bus while strobe high
// - Mode registers capture on strobe rising edge
// - Select codes map to four mode registers
// - Operating mode fields: 6:5, 4:2, 1, 0
// - Scan-end selector routes pointer to pin
// - Analog selector picks pixel, temp, externals
// - Readout bit chooses nondestructive or destructive
// - Low-power bit disables bias drivers
// - Gain register: offset 7:2, gain 1:0
// - Offset code 0-31 raises, 32-63 lowers
// - Dark level used only nondestructive; halves split
// - Column balance codes 0-127 positive correction
// - Column balance codes 128-255 negative correction
// - Line start sets both row pointers' start
// - Column start sets column pointer start
module psp_program_port #(
    parameter int BUS_W = psp_pkg::BUS_W,
    parameter int REG_W = psp_pkg::REG_W
) (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic [BUS_W-1:0]          prog_bus,
    input  wire logic                      line_start_strobe,
    input  wire logic                      column_start_strobe,
    input  wire logic                      mode_reg_strobe,
    input  wire logic                      mode_reg_clear_n,
    input  wire logic                      readout_row_pointer,
    input  wire logic                      reset_row_pointer,
    input  wire logic                      column_pointer,
    output logic [BUS_W-1:0]               line_start_value,
    output logic [BUS_W-1:0]               column_start_value,
    output psp_pkg::psp_opmode_t           operating_mode,
    output psp_pkg::psp_gain_offset_t      gain_offset,
    output logic [REG_W-1:0]               readout_dark_level,
    output logic [REG_W-1:0]               column_bus_balance,
    output logic                           scan_end_output,
    output logic [psp_pkg::NUM_SOURCES-1:0] source_select,
    output logic                           nondestructive_select,
    output logic                           bias_enable,
    output logic [3:0]                     gain_stage_factor,
    output logic                           offset_raise,
    output logic                           dark_level_active,
    output logic                           dark_level_upper,
    output logic                           balance_negative
);

    logic [REG_W-1:0] mode_regs_r [psp_pkg::NUM_MODE_REGS];
    logic [BUS_W-1:0] line_start_r;
    logic [BUS_W-1:0] column_start_r;
    logic             mode_strobe_d_r;
    logic             mode_rise;
    logic             scan_end_r;
    logic [psp_pkg::NUM_SOURCES-1:0] source_r;
    logic [psp_pkg::NUM_SOURCES-1:0] source_nxt;
    logic [3:0]       gain_factor_r;
    logic [1:0]       reg_sel;
    psp_pkg::psp_opmode_t      opmode;
    psp_pkg::psp_gain_offset_t gain_offset_reg;

    assign reg_sel   = prog_bus[psp_pkg::SEL_MSB:psp_pkg::SEL_LSB];
    assign mode_rise = mode_reg_strobe && !mode_strobe_d_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_strobe_d_r <= 1'b0;
        end else begin
            mode_strobe_d_r <= mode_reg_strobe;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            line_start_r <= psp_pkg::START_RESET;
        end else if (line_start_strobe) begin
            line_start_r <= prog_bus;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            column_start_r <= psp_pkg::START_RESET;
        end else if (column_start_strobe) begin
            column_start_r <= prog_bus;
        end
    end

    // bit 7 of operating mode masked
    for (genvar i = 0; i < psp_pkg::NUM_MODE_REGS; i++) begin : g_mode
        localparam logic [REG_W-1:0] WMASK =
            (i == int'(psp_pkg::SEL_OPERATING_MODE)) ? psp_pkg::OPMODE_WR_MASK : '1;
        always_ff @(posedge clock) begin
            if (rst || !mode_reg_clear_n) begin
                mode_regs_r[i] <= psp_pkg::MODE_REG_RESET;
            end else if (mode_rise && reg_sel == 2'(i)) begin
                mode_regs_r[i] <= prog_bus[REG_W-1:0] & WMASK;
            end
        end
    end

    assign opmode = mode_regs_r[psp_pkg::SEL_OPERATING_MODE];
    assign gain_offset_reg    = mode_regs_r[psp_pkg::SEL_GAIN_OFFSET];

    always_ff @(posedge clock) begin
        if (rst) begin
            scan_end_r <= 1'b0;
        end else if (opmode.scan_end_sel == psp_pkg::SCAN_END_READOUT_ROW) begin
            scan_end_r <= readout_row_pointer;
        end else if (opmode.scan_end_sel == psp_pkg::SCAN_END_RESET_ROW) begin
            scan_end_r <= reset_row_pointer;
        end else begin
            scan_end_r <= column_pointer;
        end
    end

    // one-hot source; unassigned codes select nothing
    always_comb begin
        source_nxt = '0;
        if (opmode.ain_sel == psp_pkg::AIN_PIXEL_ARRAY) begin
            source_nxt[psp_pkg::SRC_PIXEL] = 1'b1;
        end else if (opmode.ain_sel == psp_pkg::AIN_TEMP_SENSOR) begin
            source_nxt[psp_pkg::SRC_TEMP] = 1'b1;
        end else if (opmode.ain_sel[2]) begin
            source_nxt[psp_pkg::SRC_EXT_BASE + int'(opmode.ain_sel[1:0])] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            source_r <= '0;
        end else begin
            source_r <= source_nxt;
        end
    end

    // nominal gain 1, 2, 4, 8
    always_ff @(posedge clock) begin
        if (rst) begin
            gain_factor_r <= 4'h0;
        end else begin
            gain_factor_r <= 4'(4'h1 << gain_offset_reg.gain);
        end
    end

    assign line_start_value      = line_start_r;
    assign column_start_value    = column_start_r;
    assign operating_mode        = opmode;
    assign gain_offset           = gain_offset_reg;
    assign readout_dark_level    = mode_regs_r[psp_pkg::SEL_DARK_LEVEL];
    assign column_bus_balance    = mode_regs_r[psp_pkg::SEL_COLUMN_BALANCE];
    assign scan_end_output       = scan_end_r;
    assign source_select         = source_r;
    assign nondestructive_select = opmode.nondestructive_select;
    assign bias_enable           = !opmode.standby;
    assign gain_stage_factor     = gain_factor_r;
    assign offset_raise          = gain_offset_reg.offset < psp_pkg::OFFSET_LOWER_FIRST;
    // dark level only in nondestructive mode
    assign dark_level_active     = opmode.nondestructive_select;
    assign dark_level_upper      = readout_dark_level < psp_pkg::LEVEL_LOWER_FIRST;
    assign balance_negative      = column_bus_balance[REG_W-1];

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_line_follow;
        line_start_strobe |=> line_start_value == $past(prog_bus);
    endproperty
    a_line_follow: assert property (p_line_follow)
        else $error("line start value did not follow bus");

    property p_col_hold;
        !column_start_strobe |=> $stable(column_start_value);
    endproperty
    a_col_hold: assert property (p_col_hold)
        else $error("column start value changed without strobe");

    property p_mode_write;
        mode_reg_clear_n && mode_reg_strobe && !mode_strobe_d_r
            && reg_sel == psp_pkg::SEL_DARK_LEVEL
            |=> readout_dark_level == $past(prog_bus[7:0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("dark level not written on strobe edge");

    property p_mode_level_no_write;
        mode_reg_strobe && mode_strobe_d_r && mode_reg_clear_n
            |=> $stable(column_bus_balance) && $stable(gain_offset);
    endproperty
    a_mode_level_no_write: assert property (p_mode_level_no_write)
        else $error("mode register changed while strobe held high");

    property p_clear;
        !mode_reg_clear_n |=> operating_mode == '0 && gain_offset == '0
            && readout_dark_level == '0 && column_bus_balance == '0
            && ($past(line_start_strobe) || $stable(line_start_value));
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero mode registers");

    property p_bit7;
        operating_mode.unused == 1'b0;
    endproperty
    a_bit7: assert property (p_bit7)
        else $error("unused operating mode bit set");

    property p_scan_end;
        operating_mode.scan_end_sel[1] |=> scan_end_output == $past(column_pointer);
    endproperty
    a_scan_end: assert property (p_scan_end)
        else $error("scan-end not routed from column pointer");

    property p_source;
        ##1 $past(operating_mode.ain_sel) == 3'h5 |-> source_select == 6'h08;
    endproperty
    a_source: assert property (p_source)
        else $error("wrong analog source for code 5");

    property p_gain;
        ##1 $past(gain_offset.gain) == 2'h3 |-> gain_stage_factor == 4'h8;
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain code 3 not decoded to 8");

    property p_standby;
        bias_enable != operating_mode.standby;
    endproperty
    a_standby: assert property (p_standby)
        else $error("bias enable does not track standby");

    property p_col_follow;
        column_start_strobe |=> column_start_value == $past(prog_bus);
    endproperty
    a_col_follow: assert property (p_col_follow)
        else $error("column start value did not take the bus");

    property p_line_hold;
        !line_start_strobe |=> $stable(line_start_value);
    endproperty
    a_line_hold: assert property (p_line_hold)
        else $error("line start value changed without strobe");

    property p_opmode_write;
        mode_rise && mode_reg_clear_n && reg_sel == psp_pkg::SEL_OPERATING_MODE
            |=> operating_mode == {1'b0, $past(prog_bus[6:0])};
    endproperty
    a_opmode_write: assert property (p_opmode_write)
        else $error("operating mode not written with bit 7 cleared");

    property p_gain_write;
        mode_rise && mode_reg_clear_n && reg_sel == psp_pkg::SEL_GAIN_OFFSET
            |=> gain_offset == $past(prog_bus[7:0]);
    endproperty
    a_gain_write: assert property (p_gain_write)
        else $error("gain and offset register not written on its select");

    property p_balance_write;
        mode_rise && mode_reg_clear_n && reg_sel == psp_pkg::SEL_COLUMN_BALANCE
            |=> column_bus_balance == $past(prog_bus[7:0]);
    endproperty
    a_balance_write: assert property (p_balance_write)
        else $error("column balance register not written on its select");

    property p_mode_hold;
        !mode_rise && mode_reg_clear_n
            |=> $stable(operating_mode) && $stable(readout_dark_level);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode register changed without strobe edge");

    property p_scan_readout;
        operating_mode.scan_end_sel == psp_pkg::SCAN_END_READOUT_ROW
            |=> scan_end_output == $past(readout_row_pointer);
    endproperty
    a_scan_readout: assert property (p_scan_readout)
        else $error("scan-end not routed from readout row pointer");

    property p_scan_reset;
        operating_mode.scan_end_sel == psp_pkg::SCAN_END_RESET_ROW
            |=> scan_end_output == $past(reset_row_pointer);
    endproperty
    a_scan_reset: assert property (p_scan_reset)
        else $error("scan-end not routed from reset row pointer");

    property p_source_none;
        ##1 $past(operating_mode.ain_sel[2:1]) == 2'h1 |-> source_select == '0;
    endproperty
    a_source_none: assert property (p_source_none)
        else $error("unassigned analog code selected a source");

    c_opmode_write: cover property (mode_rise && reg_sel == 2'h0 && mode_reg_clear_n);
    c_balance_neg:  cover property (balance_negative);
    c_clear:        cover property (!mode_reg_clear_n ##1 mode_reg_clear_n);
    c_line_load:    cover property (line_start_strobe ##1 !line_start_strobe);

endmodule : psp_program_port

/* File: pkg/psp_pkg.sv */
package psp_pkg;

    // Bus and register geometry
    localparam int BUS_W         = 10;
    localparam int REG_W         = 8;
    localparam int NUM_MODE_REGS = 4;
    localparam int SEL_MSB       = 9;
    localparam int SEL_LSB       = 8;
    localparam int NUM_SOURCES   = 6;

    // Register select codes on bus bits 9:8
    localparam logic [1:0] SEL_OPERATING_MODE = 2'h0;
    localparam logic [1:0] SEL_GAIN_OFFSET    = 2'h1;
    localparam logic [1:0] SEL_DARK_LEVEL     = 2'h2;
    localparam logic [1:0] SEL_COLUMN_BALANCE = 2'h3;

    // Reset values and operating mode write mask
    localparam logic [REG_W-1:0] MODE_REG_RESET  = 8'h00;
    localparam logic [BUS_W-1:0] START_RESET     = 10'h000;
    localparam logic [REG_W-1:0] OPMODE_WR_MASK  = 8'h7F;

    // Scan-end selector codes
    localparam logic [1:0] SCAN_END_READOUT_ROW = 2'h0;
    localparam logic [1:0] SCAN_END_RESET_ROW   = 2'h1;

    // Analog source selector codes and one-hot positions
    localparam logic [2:0] AIN_PIXEL_ARRAY = 3'h0;
    localparam logic [2:0] AIN_TEMP_SENSOR = 3'h1;
    localparam int         SRC_PIXEL       = 0;
    localparam int         SRC_TEMP        = 1;
    localparam int         SRC_EXT_BASE    = 2;

    // Level split points
    localparam logic [5:0] OFFSET_LOWER_FIRST  = 6'h20;
    localparam logic [7:0] LEVEL_LOWER_FIRST   = 8'h80;

    // Bus setup / strobe width / hold, for reference by the bench
    localparam int CLK_PERIOD_NS  = 25;
    localparam int STROBE_MIN_NS  = 100;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic       unused;
        logic [1:0] scan_end_sel;
        logic [2:0] ain_sel;
        logic       nondestructive_select;
        logic       standby;
    } psp_opmode_t;

    typedef struct packed {
        logic [5:0] offset;
        logic [1:0] gain;
    } psp_gain_offset_t;

endpackage : psp_pkg

/* File: testbench/psp_ctrl_model.sv */
`timescale 1ns/1ps
module psp_ctrl_model (
    input  wire logic  clock,
    output logic [9:0] prog_bus,
    output logic       line_start_strobe,
    output logic       column_start_strobe,
    output logic       mode_reg_strobe,
    output logic       mode_reg_clear_n
);
    initial begin
        prog_bus = 10'h000;
        {mode_reg_strobe, column_start_strobe, line_start_strobe} = 3'h0;
        mode_reg_clear_n = 1'b1;
    end

    task automatic pause();
        repeat (psp_pkg::STROBE_MIN_CYC) @(negedge clock);
    endtask : pause

    task automatic cycle(input logic [1:0] which, input logic [9:0] first,
                         input logic [9:0] late);
        prog_bus = first;
        pause();
        {mode_reg_strobe, column_start_strobe, line_start_strobe} = 3'(3'h1 << which);
        pause();
        prog_bus = late;
        pause();
        {mode_reg_strobe, column_start_strobe, line_start_strobe} = 3'h0;
        pause();
        // Released bus no longer holds the value
        prog_bus = ~late;
        @(negedge clock);
    endtask : cycle

    task automatic clr();
        mode_reg_clear_n = 1'b0;
        @(negedge clock);
        mode_reg_clear_n = 1'b1;
        @(negedge clock);
    endtask : clr
endmodule : psp_ctrl_model

/* File: testbench/test_parallel_sensor_program_port.sv */
`timescale 1ns/1ps
module test_parallel_sensor_program_port;
    logic                      clock;
    logic                      rst;
    logic                      readout_row_pointer;
    logic                      reset_row_pointer;
    logic                      column_pointer;
    wire  [9:0]                prog_bus;
    wire                       line_start_strobe;
    wire                       column_start_strobe;
    wire                       mode_reg_strobe;
    wire                       mode_reg_clear_n;
    logic [9:0]                line_start_value;
    logic [9:0]                column_start_value;
    psp_pkg::psp_opmode_t      operating_mode;
    psp_pkg::psp_gain_offset_t gain_offset;
    logic [7:0]                readout_dark_level;
    logic [7:0]                column_bus_balance;
    logic                      scan_end_output;
    logic [5:0]                source_select;
    logic                      nondestructive_select;
    logic                      bias_enable;
    logic [3:0]                gain_stage_factor;
    logic                      offset_raise;
    logic                      dark_level_active;
    logic                      dark_level_upper;
    logic                      balance_negative;
    logic [7:0]                exp_r [4];
    logic [2:0]                ptr;
    int                        n_errors;
    int                        checks_done;
    int                        cycles;

    psp_ctrl_model ctrl_u (.clock, .prog_bus, .line_start_strobe, .column_start_strobe,
        .mode_reg_strobe, .mode_reg_clear_n);
    psp_program_port dut_u (.clock, .rst, .prog_bus, .line_start_strobe,
        .column_start_strobe, .mode_reg_strobe, .mode_reg_clear_n, .readout_row_pointer,
        .reset_row_pointer, .column_pointer, .line_start_value, .column_start_value,
        .operating_mode, .gain_offset, .readout_dark_level, .column_bus_balance,
        .scan_end_output, .source_select, .nondestructive_select, .bias_enable,
        .gain_stage_factor, .offset_raise, .dark_level_active, .dark_level_upper,
        .balance_negative);

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_modes();
        chk(10'(operating_mode), 10'(exp_r[0]));
        chk(10'(gain_offset), 10'(exp_r[1]));
        chk(10'(readout_dark_level), 10'(exp_r[2]));
        chk(10'(column_bus_balance), 10'(exp_r[3]));
    endtask : chk_modes

    task automatic summarize();
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        rst = 1'b1;
        {column_pointer, reset_row_pointer, readout_row_pointer} = 3'h0;
        n_errors = 0;
        checks_done = 0;
        cycles = 0;
        exp_r = '{8'h00, 8'h00, 8'h00, 8'h00};
        repeat (20) @(negedge clock);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        chk_modes();
        chk(10'(source_select), 10'h001);
        chk(10'(gain_stage_factor), 10'h001);
        $display("reset test done");
        ctrl_u.cycle(2'h0, 10'h000, 10'h3FF);
        chk(line_start_value, 10'h3FF);
        ctrl_u.cycle(2'h1, 10'h2AA, 10'h155);
        chk(column_start_value, 10'h155);
        chk(line_start_value, 10'h3FF);
        $display("start test done");
        for (int s = 0; s < 4; s++) begin
            exp_r[s] = 8'hFF - 8'(s);
            ctrl_u.cycle(2'h2, {2'(s), exp_r[s]}, {2'(s), ~exp_r[s]});
            exp_r[0][7] = 1'b0;
            chk_modes();
        end
        ctrl_u.clr();
        exp_r = '{8'h00, 8'h00, 8'h00, 8'h00};
        chk_modes();
        chk(column_start_value, 10'h155);
        chk(line_start_value, 10'h3FF);
        $display("mode test done");
        for (int a = 0; a < 8; a++) begin
            ctrl_u.cycle(2'h2, {5'h00, 3'(a), 2'(a)}, 10'h0FF);
            chk(10'(source_select), 10'((a < 2) ? 1 << a : (a > 3) ? 1 << (a - 2) : 0));
            chk(10'(nondestructive_select), 10'(a[1]));
            chk(10'(dark_level_active), 10'(a[1]));
            chk(10'(bias_enable), 10'(!a[0]));
        end
        for (int g = 0; g < 4; g++) begin
            ctrl_u.cycle(2'h2, {2'h1, 6'(31 + g), 2'(g)}, 10'h100);
            chk(10'(gain_stage_factor), 10'(1 << g));
            chk(10'(offset_raise), 10'(g == 0));
        end
        for (int k = 0; k < 2; k++) begin
            ctrl_u.cycle(2'h2, {2'h2, 8'(127 + k)}, 10'h200);
            chk(10'(dark_level_upper), 10'(k == 0));
            ctrl_u.cycle(2'h2, {2'h3, 8'(127 + k)}, 10'h300);
            chk(10'(balance_negative), 10'(k));
        end
        ctrl_u.cycle(2'h2, {2'h1, 6'h3C, 2'h0}, 10'h100);
        chk(10'(offset_raise), 10'h000);
        ctrl_u.cycle(2'h2, {2'h2, 8'h0A}, 10'h200);
        chk(10'(dark_level_upper), 10'h001);
        $display("field test done");
        for (int e = 0; e < 8; e++) begin
            if (!e[0]) begin
                ctrl_u.cycle(2'h2, {3'h0, 2'(e / 2), 5'h00}, 10'h000);
            end
            ptr = 3'(1 << ((e / 2 > 1) ? 2 : e / 2));
            {column_pointer, reset_row_pointer, readout_row_pointer} = e[0] ? ptr : ~ptr;
            repeat (2) @(negedge clock);
            chk(10'(scan_end_output), 10'(e[0]));
        end
        $display("scan end test done");
        summarize();
    end
endmodule : test_parallel_sensor_program_port
